// [core/dual_8bit_programmable_timer.sv]
// Added by the designer: strobed register access.
`timescale 1ns/1ns
`include "dual_timer_regs.svh"

module dual_8bit_programmable_timer (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        clkEn,
  input  wire logic [15:0] regAddr,
  input  wire logic [3:0]  regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [3:0]  regRdData,
  input  wire logic        lowSpeedOscillator,
  input  wire logic        highSpeedOscillator,
  input  wire logic        eventIn,
  input  wire logic        portData,
  input  wire logic        portHighZ,
  output logic             irq,
  output logic             timerWavePin,
  output logic             timerWavePinOe
);
  import dual_timer_pkg::*;

  // ==========================================================
  // derived timing
  // glitches shorter than this never reach the event counter while the noise rejector is selected
  localparam int REJECT_CYCLES_INT =
    (`NOISE_REJECT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam logic [3:0] REJECT_CYCLES = 4'(REJECT_CYCLES_INT);

  state_type stateQ;
  state_type stateD;

  // ==========================================================
  // helper functions
  // mask of prescaler bits that must be all ones for a tick
  function automatic logic [7:0] ratioMask(input logic [1:0] code);
    logic [7:0] m;
    m = 8'h00;
    unique case (code)
      2'h0: m = 8'h00;
      2'h1: m = 8'h03;
      2'h2: m = 8'h1F;
      2'h3: m = 8'hFF;
    endcase
    return m;
  endfunction

  // one prescaler output for a given source edge
  function automatic logic prescaleTick(input logic srcEdge,
                                        input logic [1:0] code,
                                        input logic [7:0] cnt);
    logic t;
    t = srcEdge && ((cnt & ratioMask(code)) == ratioMask(code));
    return t;
  endfunction

  // read a nibble of a byte
  function automatic logic [3:0] nibble(input logic [7:0] b,
                                        input logic hi);
    logic [3:0] n;
    n = hi ? b[7:4] : b[3:0];
    return n;
  endfunction

  // ==========================================================
  // next-state logic
  always_comb begin
    logic       lowEdge;
    logic       highEdge;
    logic       rawEdge;
    logic       cleanEdge;
    logic       eventEdge;
    logic       evLevel;
    logic       evPrev;
    logic [1:0] srcEdge;
    logic [1:0] preTick;
    logic [1:0] tick;
    logic [1:0] underflow;
    logic [1:0] reloadHit;
    logic [1:0] flagClear;
    lowEdge   = 1'b0;
    highEdge  = 1'b0;
    rawEdge   = 1'b0;
    cleanEdge = 1'b0;
    eventEdge = 1'b0;
    evLevel   = 1'b0;
    evPrev    = 1'b0;
    srcEdge   = 2'b00;
    preTick   = 2'b00;
    tick      = 2'b00;
    underflow = 2'b00;
    reloadHit = 2'b00;
    flagClear = 2'b00;
    stateD    = stateQ;

    // two-flop synchronisers for the pins; only stage 1 is read
    stateD.lowSync   = {stateQ.lowSync[0], lowSpeedOscillator};
    stateD.highSync  = {stateQ.highSync[0], highSpeedOscillator};
    stateD.eventSync = {stateQ.eventSync[0], eventIn};
    stateD.lowLast   = stateQ.lowSync[1];
    stateD.highLast  = stateQ.highSync[1];

    // oscillator rising edges serve as source clocks
    lowEdge  = stateQ.lowSync[1] && !stateQ.lowLast;
    highEdge = stateQ.highSync[1] && !stateQ.highLast;

    // noise rejector: level must hold for a few cycles before it is taken
    if (stateQ.eventSync[1] == stateQ.eventClean) begin
      stateD.rejectCnt = 4'h0;
    end else if (stateQ.rejectCnt >= REJECT_CYCLES - 4'h1) begin
      stateD.rejectCnt  = 4'h0;
      stateD.eventClean = stateQ.eventSync[1];
    end else begin
      stateD.rejectCnt = stateQ.rejectCnt + 4'h1;
    end

    // pick raw or filtered level, then detect the chosen edge
    evLevel = stateQ.noiseRejectSelect ? stateQ.eventClean
                                       : stateQ.eventSync[1];
    evPrev  = stateQ.eventLast;
    stateD.eventLast = evLevel;
    rawEdge   = evLevel && !evPrev;
    cleanEdge = !evLevel && evPrev;
    // polarity 1 counts rising edges, 0 falling edges
    eventEdge = stateQ.pulsePolaritySelect ? rawEdge : cleanEdge;

    // prescalers run all the time so the ratio phase stays steady
    for (int i = 0; i < 2; i++) begin
      srcEdge[i] = stateQ.sourceSelect[i] ? highEdge : lowEdge;
      if (srcEdge[i]) begin
        stateD.prescale[i] = stateQ.prescale[i] + 8'h01;
      end
      preTick[i] = prescaleTick(srcEdge[i], stateQ.ratio[i],
                                stateQ.prescale[i]);
    end

    // timer 0 clock: events or prescaler
    tick[0] = stateQ.counterModeSelect ? eventEdge : preTick[0];
    tick[1] = preTick[1];

    // reload strobes from the bus
    reloadHit[0] = regWr && regAddr == `ADDR_T0_CTRL
                   && regWrData[`BIT_RELOAD_STROBE];
    reloadHit[1] = regWr && regAddr == `ADDR_T1_CTRL
                   && regWrData[`BIT_RELOAD_STROBE];
    flagClear = (regWr && regAddr == `ADDR_IRQ_FLAGS)
                ? regWrData[1:0] : 2'b00;

    // down counters
    for (int i = 0; i < 2; i++) begin
      if (stateQ.run[i] && tick[i]) begin
        if (stateQ.count[i] == 8'h00) begin
          underflow[i]    = 1'b1;
          stateD.count[i] = stateQ.reload[i];
          stateD.wave[i]  = !stateQ.wave[i];
        end else begin
          stateD.count[i] = stateQ.count[i] - 8'h01;
        end
      end
      // a strobe overrides any count step in the same cycle
      if (reloadHit[i]) begin
        stateD.count[i] = stateQ.reload[i];
      end
      // set wins over a software clear in the same cycle
      if (underflow[i]) begin
        stateD.irqFlag[i] = 1'b1;
      end else if (flagClear[i]) begin
        stateD.irqFlag[i] = 1'b0;
      end
    end

    // register writes
    if (regWr) begin
      unique case (regAddr)
        `ADDR_EVENT_CTRL: begin
          stateD.counterModeSelect   = regWrData[`BIT_COUNTER_MODE];
          stateD.noiseRejectSelect   = regWrData[`BIT_NOISE_SEL];
          stateD.pulsePolaritySelect = regWrData[`BIT_PULSE_POL];
        end
        `ADDR_OUT_SRC_CTRL: begin
          stateD.waveChannelSelect = regWrData[`BIT_WAVE_CHAN];
          stateD.waveOutputEnable  = regWrData[`BIT_WAVE_EN];
          stateD.sourceSelect[1]   = regWrData[`BIT_SRC1];
          stateD.sourceSelect[0]   = regWrData[`BIT_SRC0];
        end
        `ADDR_T0_CTRL: begin
          stateD.ratio[0] = regWrData[`POS_RATIO +: 2];
          stateD.run[0]   = regWrData[`BIT_RUN];
        end
        `ADDR_T1_CTRL: begin
          stateD.ratio[1] = regWrData[`POS_RATIO +: 2];
          stateD.run[1]   = regWrData[`BIT_RUN];
        end
        `ADDR_T0_RELOAD_LO: stateD.reload[0][3:0] = regWrData;
        `ADDR_T0_RELOAD_HI: stateD.reload[0][7:4] = regWrData;
        `ADDR_T1_RELOAD_LO: stateD.reload[1][3:0] = regWrData;
        `ADDR_T1_RELOAD_HI: stateD.reload[1][7:4] = regWrData;
        `ADDR_IRQ_MASK: stateD.irqEnable = regWrData[1:0];
        // count registers are read only; other writes fall here
        default: stateD.irqEnable = stateD.irqEnable;
      endcase
    end

    // register reads; data stands the cycle after the strobe only
    stateD.rdData = 4'h0;
    if (regRd) begin
      unique case (regAddr)
        `ADDR_EVENT_CTRL:
          stateD.rdData = {1'b0, stateQ.counterModeSelect,
                           stateQ.noiseRejectSelect,
                           stateQ.pulsePolaritySelect};
        `ADDR_OUT_SRC_CTRL:
          stateD.rdData = {stateQ.waveChannelSelect,
                           stateQ.waveOutputEnable,
                           stateQ.sourceSelect[1],
                           stateQ.sourceSelect[0]};
        // reload strobe bit is write-only and reads 0
        `ADDR_T0_CTRL:
          stateD.rdData = {stateQ.ratio[0], 1'b0, stateQ.run[0]};
        `ADDR_T1_CTRL:
          stateD.rdData = {stateQ.ratio[1], 1'b0, stateQ.run[1]};
        `ADDR_T0_RELOAD_LO: stateD.rdData = nibble(stateQ.reload[0], 1'b0);
        `ADDR_T0_RELOAD_HI: stateD.rdData = nibble(stateQ.reload[0], 1'b1);
        `ADDR_T1_RELOAD_LO: stateD.rdData = nibble(stateQ.reload[1], 1'b0);
        `ADDR_T1_RELOAD_HI: stateD.rdData = nibble(stateQ.reload[1], 1'b1);
        `ADDR_T0_COUNT_LO: stateD.rdData = nibble(stateQ.count[0], 1'b0);
        `ADDR_T0_COUNT_HI: stateD.rdData = nibble(stateQ.count[0], 1'b1);
        `ADDR_T1_COUNT_LO: stateD.rdData = nibble(stateQ.count[1], 1'b0);
        `ADDR_T1_COUNT_HI: stateD.rdData = nibble(stateQ.count[1], 1'b1);
        `ADDR_IRQ_MASK:
          stateD.rdData = {2'b00, stateQ.irqEnable};
        `ADDR_IRQ_FLAGS:
          stateD.rdData = {2'b00, stateQ.irqFlag};
        // unmapped addresses read zero
        default: stateD.rdData = 4'h0;
      endcase
    end

    // interrupt from masked flags, using next-cycle values
    stateD.irq = |(stateD.irqFlag & stateD.irqEnable);

    // shared pin: wave replaces port data while enabled
    if (stateD.waveOutputEnable) begin
      stateD.pin = stateD.wave[stateD.waveChannelSelect];
    end else begin
      stateD.pin = portData;
    end
    // high-z control applies to either source
    stateD.pinOe = !portHighZ;
  end

  // ==========================================================
  // state register; clkEn low freezes everything
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stateQ <= '0;
    end else if (clkEn) begin
      stateQ <= stateD;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign regRdData      = stateQ.rdData;
  assign irq            = stateQ.irq;
  assign timerWavePin   = stateQ.pin;
  assign timerWavePinOe = stateQ.pinOe;

endmodule

// [common/dual_timer_regs.svh]
`ifndef DUAL_TIMER_REGS_SVH
`define DUAL_TIMER_REGS_SVH

// ==========================================================
// register offsets
`define ADDR_EVENT_CTRL    16'hFFC0
`define ADDR_OUT_SRC_CTRL  16'hFFC1
`define ADDR_T0_CTRL       16'hFFC2
`define ADDR_T1_CTRL       16'hFFC3
`define ADDR_T0_RELOAD_LO  16'hFFC4
`define ADDR_T0_RELOAD_HI  16'hFFC5
`define ADDR_T1_RELOAD_LO  16'hFFC6
`define ADDR_T1_RELOAD_HI  16'hFFC7
`define ADDR_T0_COUNT_LO   16'hFFC8
`define ADDR_T0_COUNT_HI   16'hFFC9
`define ADDR_T1_COUNT_LO   16'hFFCA
`define ADDR_T1_COUNT_HI   16'hFFCB
`define ADDR_IRQ_MASK      16'hFFE2
`define ADDR_IRQ_FLAGS     16'hFFF2

// ==========================================================
// field positions
`define BIT_PULSE_POL      0
`define BIT_NOISE_SEL      1
`define BIT_COUNTER_MODE   2
`define BIT_SRC0           0
`define BIT_SRC1           1
`define BIT_WAVE_EN        2
`define BIT_WAVE_CHAN      3
`define BIT_RUN            0
`define BIT_RELOAD_STROBE  1
`define POS_RATIO          2

// ==========================================================
// reset values and timing
`define RESET_NIBBLE       4'h0
`define RESET_BYTE         8'h00
`define NOISE_REJECT_NS    40
`define CLK_PERIOD_NS      10
`endif

// [common/dual_timer_pkg.sv]
package dual_timer_pkg;

  // ==========================================================
  // whole state of the timer block
  typedef struct packed {
    logic [1:0]      lowSync;
    logic [1:0]      highSync;
    logic [1:0]      eventSync;
    logic            lowLast;
    logic            highLast;
    logic            eventLast;
    logic [3:0]      rejectCnt;
    logic            eventClean;
    logic            counterModeSelect;
    logic            noiseRejectSelect;
    logic            pulsePolaritySelect;
    logic            waveChannelSelect;
    logic            waveOutputEnable;
    logic [1:0]      sourceSelect;
    logic [1:0][1:0] ratio;
    logic [1:0]      run;
    logic [1:0][7:0] reload;
    logic [1:0][7:0] count;
    logic [1:0][7:0] prescale;
    logic [1:0]      wave;
    logic [1:0]      irqEnable;
    logic [1:0]      irqFlag;
    logic [3:0]      rdData;
    logic            irq;
    logic            pin;
    logic            pinOe;
  } state_type;

endpackage

// [tb/dual_timer_chk.sv]
`timescale 1ns/1ns
// ==========================================================
// port-level checks on the timer block
module dual_timer_chk (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic [15:0] regAddr,
  input wire logic [3:0]  regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [3:0]  regRdData,
  input wire logic        portData,
  input wire logic        portHighZ,
  input wire logic        irq,
  input wire logic        timerWavePin,
  input wire logic        timerWavePinOe
);
  logic       waveEn_q;
  logic [1:0] mask_q;
  logic [3:0] reloadLow_q;

  // shadow copies of the controls, since the checker cannot see inside
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      waveEn_q    <= 1'b0;
      mask_q      <= 2'h0;
      reloadLow_q <= 4'h0;
    end else if (regWr) begin
      if (regAddr == 16'hFFC1) waveEn_q <= regWrData[2];
      if (regAddr == 16'hFFE2) mask_q <= regWrData[1:0];
      if (regAddr == 16'hFFC4) reloadLow_q <= regWrData;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  property p_rdIdle; !$past(regRd) |-> regRdData == 4'h0; endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data without a read");
  property p_maskUpper; regRd && regAddr == 16'hFFE2 |=> regRdData[3:2] == 2'h0; endproperty
  a_maskUpper: assert property (p_maskUpper) else $error("mask upper bits not zero");
  property p_strobeBit; regRd && regAddr[15:1] == 15'h7FE1 |=> !regRdData[1]; endproperty
  a_strobeBit: assert property (p_strobeBit) else $error("reload strobe bit reads one");
  property p_reloadRead; regRd && regAddr == 16'hFFC4 |=> regRdData == $past(reloadLow_q); endproperty
  a_reloadRead: assert property (p_reloadRead) else $error("reload nibble readback wrong");
  property p_pinOe; $past(resetn) |-> timerWavePinOe == !$past(portHighZ); endproperty
  a_pinOe: assert property (p_pinOe) else $error("pin enable does not follow high-z control");
  // both the old and new control value are off, so either pipeline choice passes
  property p_portPass;
    $past(resetn) && !waveEn_q && !$past(waveEn_q) |-> timerWavePin == $past(portData);
  endproperty
  a_portPass: assert property (p_portPass) else $error("pin not carrying port data");
  property p_irqMasked; mask_q == 2'h0 && $past(mask_q) == 2'h0 |-> !irq; endproperty
  a_irqMasked: assert property (p_irqMasked) else $error("interrupt while fully masked");
  property p_resetOut; $rose(resetn) |-> !irq && !timerWavePin && !timerWavePinOe && regRdData == 4'h0; endproperty
  a_resetOut: assert property (p_resetOut) else $error("outputs not cleared by reset");
endmodule

bind dual_8bit_programmable_timer dual_timer_chk chk (.core_clk, .resetn, .regAddr, .regWrData, .regWr, .regRd,
  .regRdData, .portData, .portHighZ, .irq, .timerWavePin, .timerWavePinOe);

// [tb/dual_timer_partner.sv]
`timescale 1ns/1ns
// ==========================================================
// oscillators and event source outside the timer block
module dual_timer_partner (
  input  wire logic core_clk,
  output logic      lowSpeedOscillator,
  output logic      highSpeedOscillator,
  output logic      eventIn
);
  logic [4:0] lowCnt_q;
  logic [2:0] highCnt_q;

  initial begin
    lowCnt_q = 5'h00;
    highCnt_q = 3'h0;
    lowSpeedOscillator = 1'b0;
    highSpeedOscillator = 1'b0;
    eventIn = 1'b0;
  end

  // phase locked to the core clock so tick spacing is exact; real crystals drift
  always @(posedge core_clk) begin
    lowCnt_q <= (lowCnt_q == 5'h13) ? 5'h00 : lowCnt_q + 5'h01;
    highCnt_q <= highCnt_q + 3'h1;
    lowSpeedOscillator <= lowCnt_q < 5'h0A; // 20 cycle period
    highSpeedOscillator <= highCnt_q[2];    // 8 cycle period
  end

  // event line level held for a number of cycles
  task automatic drive(input logic lvl, input int hold);
    @(posedge core_clk);
    eventIn <= lvl;
    repeat (hold) @(posedge core_clk);
  endtask
endmodule

// [tb/dual_8bit_programmable_timer_bench.sv]
`timescale 1ns/1ns
module dual_8bit_programmable_timer_bench;
  logic        core_clk;
  logic        resetn;
  logic [15:0] regAddr;
  logic [3:0]  regWrData;
  logic        regWr;
  logic        regRd;
  logic [3:0]  regRdData;
  logic        lowSpeedOscillator;
  logic        highSpeedOscillator;
  logic        eventIn;
  logic        portData;
  logic        portHighZ;
  logic        irq;
  logic        timerWavePin;
  logic        timerWavePinOe;
  int          bad_count;
  int          checks_done;
  int          gap;
  int          cnt;
  logic [3:0]  val;
  logic [15:0] regMap [15] = '{16'hFFC0, 16'hFFC1, 16'hFFC2, 16'hFFC3, 16'hFFC4, 16'hFFC5, 16'hFFC6, 16'hFFC7,
                               16'hFFC8, 16'hFFC9, 16'hFFCA, 16'hFFCB, 16'hFFE2, 16'hFFF2, 16'hFFD0};

  dual_8bit_programmable_timer uut (.core_clk, .resetn, .clkEn(1'b1), .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .lowSpeedOscillator, .highSpeedOscillator, .eventIn, .portData, .portHighZ, .irq,
    .timerWavePin, .timerWavePinOe);
  dual_timer_partner far (.core_clk, .lowSpeedOscillator, .highSpeedOscillator, .eventIn);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // port side of the shared pin wanders at random
  always @(posedge core_clk) begin
    portData <= 1'($urandom);
    portHighZ <= 1'($urandom);
  end

  // ==========================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic expectReg(input logic [15:0] a, input logic [3:0] exp);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 check({12'h000, regRdData}, {12'h000, exp});
  endtask
  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  // cycles until the pin next changes; bounded so a dead timer cannot hang the run
  task automatic waitToggle(output int n);
    logic last;
    n = 0;
    #1 last = timerWavePin;
    do begin
      @(posedge core_clk);
      #1 n++;
      if (n > 4000) begin
        check(16'h0000, 16'h0001);
        summarize();
      end
    end while (timerWavePin === last);
  endtask
  // wave half period: divider times source period, reload 0 so one tick per underflow
  function automatic logic [15:0] expGap(input int k);
    logic [15:0] div;
    div = (k % 4 == 0) ? 16'h0001 : (k % 4 == 1) ? 16'h0004 : (k % 4 == 2) ? 16'h0020 : 16'h0100;
    return div * ((k < 4) ? 16'h0008 : 16'h0014);
  endfunction

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h00C0));
    resetn = 1'b0;
    regAddr = 16'h0000;
    regWrData = 4'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    bad_count = 0;
    checks_done = 0;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    foreach (regMap[i]) expectReg(regMap[i], 4'h0);
    // reload nibbles keep random data, count nibbles ignore writes
    for (int i = 0; i < 4; i++) begin
      val = 4'($urandom);
      wr(16'hFFC4 + 16'(i), val);
      expectReg(16'hFFC4 + 16'(i), val);
      wr(16'hFFC8 + 16'(i), ~val);
      expectReg(16'hFFC8 + 16'(i), 4'h0);
    end
    // event counting: every polarity and rejector setting, with a short glitch
    wr(16'hFFC4, 4'h9);
    wr(16'hFFC5, 4'h0);
    for (int m = 0; m < 4; m++) begin
      cnt = 9;
      wr(16'hFFC0, 4'(4 + m));
      wr(16'hFFC2, 4'hE);
      expectReg(16'hFFC2, 4'hC);
      expectReg(16'hFFC8, 4'h9);
      wr(16'hFFC2, 4'h1);
      far.drive(1'b1, 1);
      far.drive(1'b0, 12);
      cnt -= (m < 2);
      expectReg(16'hFFC8, 4'(cnt));
      far.drive(1'b1, 12);
      cnt -= m % 2;
      expectReg(16'hFFC8, 4'(cnt));
      far.drive(1'b0, 12);
      cnt -= 1 - m % 2;
      expectReg(16'hFFC8, 4'(cnt));
    end
    wr(16'hFFC2, 4'h0);
    // timer 1 wave on the pin: all ratio codes on the fast source, one on the slow
    wr(16'hFFC6, 4'h0);
    wr(16'hFFC7, 4'h0);
    wr(16'hFFE2, 4'h2);
    for (int k = 0; k < 5; k++) begin
      // timer 1 follows its own source bit, so the fast/slow choice goes on that bit
      wr(16'hFFC1, {2'b11, 1'(k < 4), 1'b0});
      wr(16'hFFC3, {2'(k), 2'b11});
      repeat (3) waitToggle(gap);
      check(16'(gap), expGap(k));
    end
    // channel 0 selected: stopped timer 0 leaves the pin still
    wr(16'hFFC1, 4'h4);
    settle();
    val[0] = timerWavePin;
    cnt = 0;
    repeat (100) begin
      @(posedge core_clk);
      #1 cnt += (timerWavePin !== val[0]);
    end
    check(16'(cnt), 16'h0000);
    wr(16'hFFC1, 4'h0);
    // flag, mask and write-one clear
    wr(16'hFFC3, 4'h0);
    expectReg(16'hFFF2, 4'h2);
    wr(16'hFFE2, 4'h0);
    settle();
    check({15'h0000, irq}, 16'h0000);
    wr(16'hFFE2, 4'h2);
    settle();
    check({15'h0000, irq}, 16'h0001);
    expectReg(16'hFFE2, 4'h2);
    wr(16'hFFF2, 4'h1);
    expectReg(16'hFFF2, 4'h2);
    wr(16'hFFF2, 4'h2);
    expectReg(16'hFFF2, 4'h0);
    settle();
    check({15'h0000, irq}, 16'h0000);
    summarize();
  end
endmodule
